//--- hw/byte_alu_consts.vh
// Constants for the byte ALU instruction subset block
// Functional notes
// - The halt instruction clears the power-down flag and sets the time-out flag.
// - The halt instruction zeroes the watchdog counter and its prescaler count.
// - After the halt instruction the core stops executing until a wake event.
// - Rotate right shifts through carry: carry into bit 7, bit 0 into carry, no other flag.
// - Literal minus acc goes to acc; carry when acc <= literal, digit carry on low nibbles.
// - File minus acc: carry clear when acc > file, digit carry by low nibbles, zero updated.
// - In file forms, destination bit 0 selects the accumulator and 1 the file register.
// - File exclusive-OR of acc and file register goes to the destination, affecting only zero.
// - Nibble swap exchanges the file register nibbles into the destination, affecting no flag.
// - Literal exclusive-OR of acc and immediate goes to acc, affecting only zero.
`ifndef BYTE_ALU_CONSTS_VH
`define BYTE_ALU_CONSTS_VH

// AXI4-Lite register byte addresses
`define REG_CTRL        8'h00
`define REG_OPERAND     8'h04
`define REG_ACC         8'h08
`define REG_STATUS      8'h0c
`define REG_WATCHDOG    8'h10
`define REG_FILE_BASE   8'h80
`define FILE_BASE_IDX   6'h20

// Opcode field values in REG_CTRL[2:0]
`define OP_HALT         3'h0
`define OP_ROTATE_RIGHT 3'h1
`define OP_LIT_MINUS    3'h2
`define OP_FILE_MINUS   3'h3
`define OP_XOR_FILE     3'h4
`define OP_SWAP         3'h5
`define OP_XOR_LIT      3'h6
`define OP_NOP          3'h7

// REG_CTRL field positions
`define CTRL_DEST_BIT   3
`define CTRL_GO_BIT     4
`define CTRL_WAKE_BIT   5

// REG_STATUS field positions
`define ST_CARRY        0
`define ST_DIGIT        1
`define ST_ZERO         2
`define ST_POWER_DOWN   3
`define ST_TIME_OUT     4
`define ST_HALTED       5

// Status reset value, watchdog prescaler top and file depth
`define STATUS_RESET    6'h18
`define WATCHDOG_PRESC_TOP 8'hff
`define FILE_DEPTH      32

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

//--- hw/byte_alu_exec.v
// Byte ALU instruction subset executor with AXI4-Lite register access
`include "byte_alu_consts.vh"

module byte_alu_exec (
  input  wire        SYS_CLK,       // 10 MHz core clock
  input  wire        RST_B,         // Async reset, active low
  input  wire [7:0]  AWADDR,        // Write address
  input  wire        AWVALID,       // Write address valid
  output reg         AWREADY,       // Write address ready
  input  wire [31:0] WDATA,         // Write data
  input  wire [3:0]  WSTRB,         // Write byte strobes
  input  wire        WVALID,        // Write data valid
  output reg         WREADY,        // Write data ready
  output reg  [1:0]  BRESP,         // Write response
  output reg         BVALID,        // Write response valid
  input  wire        BREADY,        // Write response ready
  input  wire [7:0]  ARADDR,        // Read address
  input  wire        ARVALID,       // Read address valid
  output reg         ARREADY,       // Read address ready
  output reg  [31:0] RDATA,         // Read data
  output reg  [1:0]  RRESP,         // Read response
  output reg         RVALID,        // Read response valid
  input  wire        RREADY,        // Read response ready
  output reg         HALTED         // Core in halt state
);

  // Architectural state
  reg  [7:0]  acc;
  reg  [7:0]  file_mem [0:`FILE_DEPTH-1];
  reg  [2:0]  opcode;
  reg         dest;
  reg  [4:0]  file_addr;
  reg  [7:0]  literal;
  reg         carry;
  reg         digit;
  reg         zero;
  reg         power_down_flag;
  reg         time_out_flag;
  reg  [7:0]  watchdog_counter;
  reg  [7:0]  watchdog_presc;

  // Write channel holding
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  // Execution datapath outputs
  reg  [7:0]  result;
  reg         next_carry;
  reg         next_digit;
  reg         upd_c;
  reg         upd_dc;
  reg         upd_z;
  reg         to_file;
  reg         writes;
  reg  [8:0]  diff;
  reg  [4:0]  diff_lo;

  wire [7:0]  file_val = file_mem[file_addr];
  wire        do_write = aw_held && w_held && !BVALID;
  wire        is_file  = aw_addr[7];
  wire        wr_ctrl  = do_write && aw_addr == `REG_CTRL;
  wire        go       = wr_ctrl && w_strb[0] && w_data[`CTRL_GO_BIT];
  wire        wake     = wr_ctrl && w_strb[0] && w_data[`CTRL_WAKE_BIT];
  wire        exec     = go && !HALTED;
  wire [2:0]  wr_op    = w_data[2:0];
  wire        halt_now   = exec && wr_op == `OP_HALT;
  wire        wr_operand = do_write && aw_addr == `REG_OPERAND;
  wire        wr_acc     = do_write && aw_addr == `REG_ACC;

  // Status reset pattern, split per flag below
  localparam [5:0] status_init = `STATUS_RESET;

  // Instruction datapath
  always @* begin
    result     = 8'h00;
    next_carry = carry;
    next_digit = digit;
    upd_c      = 1'b0;
    upd_dc     = 1'b0;
    upd_z      = 1'b0;
    to_file    = 1'b0;
    writes     = 1'b0;
    diff       = 9'h000;
    diff_lo    = 5'h00;
    case (wr_op)
      `OP_ROTATE_RIGHT: begin
        result     = {carry, file_val[7:1]};
        next_carry = file_val[0];
        upd_c      = 1'b1;
        writes     = 1'b1;
        to_file    = w_data[`CTRL_DEST_BIT];
      end
      `OP_LIT_MINUS: begin
        diff       = {1'b0, literal} + {1'b0, ~acc} + 9'h001;
        diff_lo    = {1'b0, literal[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        result     = diff[7:0];
        next_carry = diff[8];
        next_digit = diff_lo[4];
        upd_c      = 1'b1;
        upd_dc     = 1'b1;
        upd_z      = 1'b1;
        writes     = 1'b1;
      end
      `OP_FILE_MINUS: begin
        diff       = {1'b0, file_val} + {1'b0, ~acc} + 9'h001;
        diff_lo    = {1'b0, file_val[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        result     = diff[7:0];
        next_carry = diff[8];
        next_digit = diff_lo[4];
        upd_c      = 1'b1;
        upd_dc     = 1'b1;
        upd_z      = 1'b1;
        writes     = 1'b1;
        to_file    = w_data[`CTRL_DEST_BIT];
      end
      `OP_XOR_FILE: begin
        result  = acc ^ file_val;
        upd_z   = 1'b1;
        writes  = 1'b1;
        to_file = w_data[`CTRL_DEST_BIT];
      end
      `OP_SWAP: begin
        result  = {file_val[3:0], file_val[7:4]};
        writes  = 1'b1;
        to_file = w_data[`CTRL_DEST_BIT];
      end
      `OP_XOR_LIT: begin
        result = acc ^ literal;
        upd_z  = 1'b1;
        writes = 1'b1;
      end
      default: begin
        writes = 1'b0;
      end
    endcase
  end

  // Watchdog prescaler and counter, frozen while halted, cleared by halt
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      watchdog_counter <= 8'h00;
      watchdog_presc   <= 8'h00;
    end else if (halt_now) begin
      watchdog_counter <= 8'h00;
      watchdog_presc   <= 8'h00;
    end else if (!HALTED) begin
      if (watchdog_presc == `WATCHDOG_PRESC_TOP) begin
        watchdog_presc   <= 8'h00;
        watchdog_counter <= watchdog_counter + 8'h01;
      end else begin
        watchdog_presc <= watchdog_presc + 8'h01;
      end
    end
  end

  // Operand register: literal and file address
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      literal   <= 8'h00;
      file_addr <= 5'h00;
    end else if (wr_operand) begin
      if (w_strb[0])
        literal <= w_data[7:0];
      if (w_strb[1])
        file_addr <= w_data[12:8];
    end
  end

  // Last opcode and destination written to the control register
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      opcode <= `OP_NOP;
      dest   <= 1'b0;
    end else if (wr_ctrl && w_strb[0]) begin
      opcode <= wr_op;
      dest   <= w_data[`CTRL_DEST_BIT];
    end
  end

  // Accumulator: instruction result or software write
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      acc <= 8'h00;
    end else if (exec && writes && !to_file) begin
      acc <= result;
    end else if (wr_acc && w_strb[0]) begin
      acc <= w_data[7:0];
    end
  end

  // Arithmetic flags, each touched only by the instructions that own it
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      carry <= status_init[`ST_CARRY];
      digit <= status_init[`ST_DIGIT];
      zero  <= status_init[`ST_ZERO];
    end else if (exec && writes) begin
      if (upd_c)
        carry <= next_carry;
      if (upd_dc)
        digit <= next_digit;
      if (upd_z)
        zero <= (result == 8'h00);
    end
  end

  // Halt state and power flags; halt in the same write beats wake
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      power_down_flag <= status_init[`ST_POWER_DOWN];
      time_out_flag   <= status_init[`ST_TIME_OUT];
      HALTED          <= status_init[`ST_HALTED];
    end else begin
      if (wake)
        HALTED <= 1'b0;
      if (halt_now) begin
        power_down_flag <= 1'b0;
        time_out_flag   <= 1'b1;
        HALTED          <= 1'b1;
      end
    end
  end

  // File register storage, written by software or instruction results
  always @(posedge SYS_CLK) begin
    if (exec && writes && to_file)
      file_mem[file_addr] <= result;
    else if (do_write && is_file && w_strb[0])
      file_mem[aw_addr[6:2]] <= w_data[7:0];
  end

  // AXI write channel: take address and data in either order
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      BVALID  <= 1'b0;
      BRESP   <= `RESP_OKAY;
    end else begin
      AWREADY <= !aw_held && !AWREADY && AWVALID;
      WREADY  <= !w_held && !WREADY && WVALID;
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= {AWADDR[7:2], 2'b00};
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        BVALID  <= 1'b1;
        BRESP   <= (is_file || aw_addr == `REG_CTRL || aw_addr == `REG_OPERAND ||
                    aw_addr == `REG_ACC) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // AXI read channel
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= `RESP_OKAY;
    end else begin
      ARREADY <= !ARREADY && !RVALID && ARVALID;
      if (ARVALID && ARREADY) begin
        RVALID <= 1'b1;
        RRESP  <= `RESP_OKAY;
        if (ARADDR[7])
          RDATA <= {24'h000000, file_mem[ARADDR[6:2]]};
        else begin
          case ({ARADDR[7:2], 2'b00})
            `REG_CTRL:     RDATA <= {26'h0000000, 1'b0, 1'b0, dest, opcode};
            `REG_OPERAND:  RDATA <= {19'h00000, file_addr, literal};
            `REG_ACC:      RDATA <= {24'h000000, acc};
            `REG_STATUS:   RDATA <= {26'h0000000, HALTED, time_out_flag,
                                     power_down_flag, zero, digit, carry};
            `REG_WATCHDOG: RDATA <= {16'h0000, watchdog_presc, watchdog_counter};
            default: begin
              RDATA <= 32'h00000000;
              RRESP <= `RESP_SLVERR;
            end
          endcase
        end
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

endmodule // byte_alu_exec

//--- sim/byte_alu_exec_assertions.sv
// Port checker for the byte ALU executor
`include "byte_alu_consts.vh"
module byte_alu_exec_chk (
  input wire        SYS_CLK, // Clock
  input wire        RST_B,   // Reset
  input wire [7:0]  ARADDR,  // Read addr
  input wire        ARVALID, // Addr valid
  input wire        ARREADY, // Addr ready
  input wire [31:0] RDATA,   // Read data
  input wire [1:0]  RRESP,   // Read resp
  input wire        RVALID,  // Resp valid
  input wire        BVALID,  // Write resp
  input wire        HALTED   // Halt state
);
  reg  [7:0] ra; // Read addr in flight
  wire       st_rd = RVALID && ra == `REG_STATUS;
  // Latch the taken read address
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B)
      ra <= 8'h00;
    else if (ARVALID && ARREADY)
      ra <= ARADDR;
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  a_power_down_clear: assert property (st_rd && HALTED |-> !RDATA[`ST_POWER_DOWN])
    else $error("power-down flag set while halted");
  a_time_out_set: assert property (st_rd && HALTED |-> RDATA[`ST_TIME_OUT])
    else $error("time-out flag clear while halted");
  a_halt_bit_shown: assert property (st_rd |-> RDATA[`ST_HALTED] == HALTED)
    else $error("status halt bit differs from halt port");
  a_watchdog_held_zero: assert property (RVALID && ra == `REG_WATCHDOG && HALTED |->
    RDATA[15:0] == 16'h0000)
    else $error("watchdog not zero while halted");
  a_halt_at_commit: assert property ($rose(HALTED) |-> $rose(BVALID))
    else $error("halt entered outside a write commit");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  a_upper_zero: assert property (RVALID |-> RDATA[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_slverr_zero: assert property (RVALID && RRESP == `RESP_SLVERR |-> RDATA == 32'h0)
    else $error("error read carries data");
  c_halt_status: cover property (st_rd && HALTED);
  c_halt_entry: cover property ($rose(HALTED));
  c_slverr: cover property (RVALID && RRESP == `RESP_SLVERR);
endmodule // byte_alu_exec_chk
bind byte_alu_exec byte_alu_exec_chk chk (.SYS_CLK, .RST_B, .ARADDR, .ARVALID, .ARREADY,
  .RDATA, .RRESP, .RVALID, .BVALID, .HALTED);

//--- sim/tb_byte_alu_exec.sv
// Self-checking bench for the byte ALU executor
module tb_byte_alu_exec;
  timeunit 1ns;
  timeprecision 1ns;
  reg        SYS_CLK = 1'b0, RST_B = 1'b0, AWVALID = 1'b0, WVALID = 1'b0;
  reg        BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  reg [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
  reg [31:0] WDATA = 32'h0, rd;
  reg [3:0]  WSTRB = 4'hf;
  reg [1:0]  rs;
  wire       AWREADY, WREADY, BVALID, ARREADY, RVALID, HALTED;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  int n_errors = 0, checked = 0, seed = 93, acc, c, dig, z, pwr_dn = 1, t_out = 1;
  int r, i, op, ds, fa, lt;
  int f[32];
  byte_alu_exec DUT (.SYS_CLK, .RST_B, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
    .RREADY, .HALTED);
  // Clock
  always #50 SYS_CLK = ~SYS_CLK;
  task automatic chk(input [31:0] seen, input [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge SYS_CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    rs = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic rdr(input [7:0] a);
    @(posedge SYS_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    rd = RDATA;
    rs = RRESP;
    RREADY <= 1'b0;
  endtask
  // Reference model of one instruction
  task automatic step(input int o, input int d);
    int v, b;
    v = f[fa];
    b = (o == 2) ? lt : v;
    r = (o == 1) ? (c << 7) | (v >> 1) : (o < 4) ? (b - acc) & 8'hff : (o == 4) ? acc ^ v
      : (o == 5) ? ((v & 4'hf) << 4) | (v >> 4) : acc ^ lt;
    if (o == 1) c = v & 1;
    if (o == 2 || o == 3) begin
      c = acc <= b;
      dig = (acc & 4'hf) <= (b & 4'hf);
    end
    if (o != 1 && o != 5) z = (r == 0);
    if (d == 1 && o != 2 && o != 6) f[fa] = r;
    else acc = r;
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    rdr(8'h0c);
    chk(rd, 32'h18);
    for (i = 0; i < 32; i++) begin
      f[i] = $random(seed) & 8'hff;
      wr(8'(8'h80 + 4 * i), f[i]);
    end
    for (i = 0; i < 80; i++) begin
      op = 1 + ($unsigned($random(seed)) % 6);
      ds = $random(seed) & 1;
      fa = $random(seed) & 5'h1f;
      acc = $random(seed) & 8'hff;
      lt = (i % 4 == 0) ? acc : $random(seed) & 8'hff;
      wr(8'h08, acc);
      wr(8'h04, (fa << 8) | lt);
      wr(8'h00, 32'h10 | (ds << 3) | op);
      step(op, ds);
      rdr(8'h08);
      chk(rd, acc);
      rdr(8'h0c);
      chk(rd, {t_out[0], pwr_dn[0], z[0], dig[0], c[0]});
      rdr(8'(8'h80 + 4 * fa));
      chk(rd, f[fa]);
    end
    wr(8'h00, 32'h10);
    chk(HALTED, 1'b1);
    pwr_dn = 0;
    t_out = 1;
    rdr(8'h0c);
    chk(rd, {1'b1, t_out[0], pwr_dn[0], z[0], dig[0], c[0]});
    rdr(8'h10);
    chk(rd, 32'h0);
    wr(8'h00, 32'h16);
    rdr(8'h08);
    chk(rd, acc);
    wr(8'h00, 32'h27);
    chk(HALTED, 1'b0);
    wr(8'h00, 32'h17);
    rdr(8'h08);
    chk(rd, acc);
    wr(8'h00, 32'h16);
    step(6, 0);
    rdr(8'h08);
    chk(rd, acc);
    rdr(8'h0c);
    chk(rd, {t_out[0], pwr_dn[0], z[0], dig[0], c[0]});
    wr(8'h40, 32'h1);
    chk(rs, 2'h2);
    rdr(8'h40);
    chk(rs, 2'h2);
    wrap_up;
  end
  // Watchdog against a hang
  initial begin
    #3000000;
    n_errors++;
    wrap_up;
  end
endmodule // tb_byte_alu_exec
